/* File: verilog/chw_defines.svh */
`ifndef CHW_DEFINES_SVH
`define CHW_DEFINES_SVH

// ***********************************************************
// debug port command codes
// ***********************************************************
`define CHW_LOAD_CORE_CMD   8'h60
`define CHW_LOAD_MEM_CMD    8'h61
`define CHW_STORE_CORE_CMD  8'h40
`define CHW_STORE_MEM_CMD   8'h41

// ***********************************************************
// data register indices and field positions
// ***********************************************************
`define CHW_CORE_IDX        1'b0
`define CHW_MEM_IDX         1'b1
`define CHW_FAMILY_LSB      24
`define CHW_GEN_LSB         20
`define CHW_REV_LSB         16
`define CHW_MAC_BIT         15
`define CHW_DIV_BIT         14
`define CHW_ENHANCED_MULTIPLY_ACCUMULATE_PRESENT_BIT        13
`define CHW_FPU_BIT         12
`define CHW_ISA_LSB         4
`define CHW_DEBUG_LSB       0
`define CHW_FLASH_LSB       19
`define CHW_SRAM_LSB        3

// ***********************************************************
// fixed codes and default values
// ***********************************************************
`define CHW_ISA_LEVEL_C     4'h2
`define CHW_DEBUG_LEVEL     4'h9
`define CHW_MEM_FIXED       32'h1000_1000
`define CHW_FLASH_DEFAULT   5'h08
`define CHW_SRAM_DEFAULT    5'h0e

`endif

/* File: verilog/chw_pkg.sv */
package chw_pkg;
   // load sequencer states
   typedef enum logic [1:0] {
      ST_RESET,
      ST_LOAD_CORE,
      ST_LOAD_MEM,
      ST_RUN
   } chw_state_t;

   typedef logic [31:0] chw_word_t;
   typedef logic        chw_idx_t;
endpackage

/* File: verilog/chw_cfg_store.sv */
`timescale 1ns/100ps
// ***********************************************************
// two-word data register store, registered read ports
// ***********************************************************
module chw_cfg_store #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2,
   parameter int AW    = 1
) (
   input  wire logic             core_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             we_i,
   input  wire logic [AW-1:0]    waddr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   input  wire logic [AW-1:0]    ra_addr_i,
   output logic      [WIDTH-1:0] ra_data_o,
   input  wire logic [AW-1:0]    rb_addr_i,
   output logic      [WIDTH-1:0] rb_data_o
);
   logic [WIDTH-1:0] mem_reg [DEPTH];

   // storage; only the loader writes it
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else if (we_i) begin
         mem_reg[waddr_i] <= wdata_i;
      end
   end

   // read data always leave through a flop
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ra_data_o <= '0;
         rb_data_o <= '0;
      end else begin
         ra_data_o <= mem_reg[ra_addr_i];
         rb_data_o <= mem_reg[rb_addr_i];
      end
   end
endmodule

/* File: verilog/chw_config_words.sv */
`timescale 1ns/100ps
`include "chw_defines.svh"
module chw_config_words #(
   parameter logic [7:0] FAMILY_CODE  = 8'ha5, // arbitrary value
   parameter logic [3:0] GEN_CODE     = 4'h3,  // arbitrary value
   parameter logic [3:0] REV_CODE     = 4'h2,  // arbitrary value
   parameter logic       MAC_PRESENT  = 1'b1,
   parameter logic [4:0] FLASH_CODE   = `CHW_FLASH_DEFAULT,
   parameter logic [4:0] SRAM_CODE    = `CHW_SRAM_DEFAULT
) (
   input  wire logic              core_clk_i,
   input  wire logic              reset_n_i,
   input  wire logic              cpu_rd_i,
   input  wire chw_pkg::chw_idx_t cpu_sel_i,
   input  wire logic              cpu_wr_i,
   output chw_pkg::chw_word_t     cpu_rdata_o,
   output logic                   cpu_rvalid_o,
   output logic                   write_refused_o,
   input  wire logic              dbg_cmd_valid_i,
   input  wire logic [7:0]        dbg_cmd_i,
   output chw_pkg::chw_word_t     dbg_rdata_o,
   output logic                   dbg_rvalid_o,
   output logic                   dbg_error_o,
   output logic                   core_ready_o
);
   import chw_pkg::*;

   // ********************************************************
   // word assembly
   // ********************************************************
   // reserved positions start at zero and stay there
   function automatic chw_word_t build_core_word();
      chw_word_t w;
      w = '0;
      w[`CHW_FAMILY_LSB +: 8] = FAMILY_CODE;
      w[`CHW_GEN_LSB +: 4]    = GEN_CODE;
      w[`CHW_REV_LSB +: 4]    = REV_CODE;
      w[`CHW_MAC_BIT]         = MAC_PRESENT;
      w[`CHW_DIV_BIT]         = 1'b0;
      w[`CHW_ENHANCED_MULTIPLY_ACCUMULATE_PRESENT_BIT]        = 1'b0;
      w[`CHW_FPU_BIT]         = 1'b0;
      w[`CHW_ISA_LSB +: 4]    = `CHW_ISA_LEVEL_C;
      w[`CHW_DEBUG_LSB +: 4]  = `CHW_DEBUG_LEVEL;
      return w;
   endfunction

   function automatic chw_word_t build_mem_word();
      chw_word_t w;
      w = `CHW_MEM_FIXED;
      w[`CHW_FLASH_LSB +: 5] = FLASH_CODE;
      w[`CHW_SRAM_LSB +: 5]  = SRAM_CODE;
      return w;
   endfunction

   // decode of a debug load; used for read and for refusal
   function automatic logic is_load(input logic [7:0] cmd);
      return (cmd == `CHW_LOAD_CORE_CMD) || (cmd == `CHW_LOAD_MEM_CMD);
   endfunction

   // ********************************************************
   // load sequencer
   // ********************************************************
   chw_state_t state_reg;
   chw_state_t state_next;
   logic       ready_reg;
   logic       ready_next;
   logic       load_we;
   chw_idx_t   load_idx;
   chw_word_t  load_data;

   // one word per cycle after release, ready only once both are in
   always_comb begin
      state_next = state_reg;
      load_we    = 1'b0;
      load_idx   = `CHW_CORE_IDX;
      load_data  = build_core_word();
      case (state_reg)
         ST_RESET: begin
            state_next = ST_LOAD_CORE;
         end
         ST_LOAD_CORE: begin
            load_we    = 1'b1;
            state_next = ST_LOAD_MEM;
         end
         ST_LOAD_MEM: begin
            load_we    = 1'b1;
            load_idx   = `CHW_MEM_IDX;
            load_data  = build_mem_word();
            state_next = ST_RUN;
         end
         ST_RUN: begin
            state_next = ST_RUN;
         end
         default: begin
            state_next = ST_RESET;
         end
      endcase
      ready_next = ready_reg || (state_reg == ST_LOAD_MEM);
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= ST_RESET;
         ready_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ready_reg <= ready_next;
      end
   end

   // ********************************************************
   // access handling
   // ********************************************************
   logic     cpu_rvalid_reg;
   logic     cpu_rvalid_next;
   logic     refused_reg;
   logic     refused_next;
   logic     dbg_rvalid_reg;
   logic     dbg_rvalid_next;
   logic     dbg_err_reg;
   logic     dbg_err_next;
   chw_idx_t dbg_idx;

   // no write path exists to the store: software writes only flag
   always_comb begin
      dbg_idx         = (dbg_cmd_i == `CHW_LOAD_MEM_CMD);
      cpu_rvalid_next = cpu_rd_i && ready_reg;
      refused_next    = cpu_wr_i;
      dbg_rvalid_next = dbg_cmd_valid_i && ready_reg
                        && is_load(dbg_cmd_i);
      // stores and unknown codes are refused, as is early access
      dbg_err_next    = dbg_cmd_valid_i
                        && !(ready_reg && is_load(dbg_cmd_i));
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cpu_rvalid_reg <= 1'b0;
         refused_reg    <= 1'b0;
         dbg_rvalid_reg <= 1'b0;
         dbg_err_reg    <= 1'b0;
      end else begin
         cpu_rvalid_reg <= cpu_rvalid_next;
         refused_reg    <= refused_next;
         dbg_rvalid_reg <= dbg_rvalid_next;
         dbg_err_reg    <= dbg_err_next;
      end
   end

   chw_cfg_store #(
      .WIDTH (32),
      .DEPTH (2),
      .AW    (1)
   ) u_store (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .we_i       (load_we),
      .waddr_i    (load_idx),
      .wdata_i    (load_data),
      .ra_addr_i  (cpu_sel_i),
      .ra_data_o  (cpu_rdata_o),
      .rb_addr_i  (dbg_idx),
      .rb_data_o  (dbg_rdata_o)
   );

   assign cpu_rvalid_o    = cpu_rvalid_reg;
   assign write_refused_o = refused_reg;
   assign dbg_rvalid_o    = dbg_rvalid_reg;
   assign dbg_error_o     = dbg_err_reg;
   assign core_ready_o    = ready_reg;

   // ********************************************************
   // checks
   // ********************************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence seq_core_load;
      state_reg == ST_LOAD_CORE && load_we && !load_idx;
   endsequence
   sequence seq_mem_load;
      state_reg == ST_LOAD_MEM && load_we && load_idx;
   endsequence
   sequence seq_core_rd;
      dbg_rvalid_o && $past(dbg_cmd_i) == `CHW_LOAD_CORE_CMD;
   endsequence
   sequence seq_mem_rd;
      cpu_rvalid_o && $past(cpu_sel_i) == `CHW_MEM_IDX;
   endsequence

   chk_load_order: assert property (
      state_reg == ST_RESET |=> seq_core_load ##1 seq_mem_load
                               ##1 core_ready_o)
      else $error("config words not loaded in order after reset");
   chk_family_field: assert property (
      seq_core_rd |-> dbg_rdata_o[31:24] == FAMILY_CODE)
      else $error("family code wrong");
   chk_gen_rev: assert property (
      seq_core_rd |-> dbg_rdata_o[23:16] == {GEN_CODE, REV_CODE})
      else $error("generation or revision wrong");
   chk_engine_bits: assert property (
      seq_core_rd |-> dbg_rdata_o[15:12] == {MAC_PRESENT, 3'b000})
      else $error("engine presence bits wrong");
   chk_isa_debug: assert property (
      seq_core_rd |-> dbg_rdata_o[11:0] == 12'h029)
      else $error("instruction set or debug level wrong");
   chk_mem_word: assert property (
      seq_mem_rd |-> cpu_rdata_o == (32'h1000_1000
         | {8'h00, FLASH_CODE, 11'h000, SRAM_CODE, 3'b000}))
      else $error("memory word wrong");
   chk_store_refused: assert property (
      dbg_cmd_valid_i && dbg_cmd_i == `CHW_STORE_MEM_CMD
      |=> dbg_error_o && !dbg_rvalid_o)
      else $error("debug store not refused");
   chk_debug_read: assert property (
      dbg_cmd_valid_i && core_ready_o && is_load(dbg_cmd_i)
      |=> dbg_rvalid_o && !dbg_error_o)
      else $error("debug load not answered");
   chk_write_ignored: assert property (
      core_ready_o && cpu_wr_i |=> write_refused_o
      ##0 $stable(u_store.mem_reg[0]) ##0 $stable(u_store.mem_reg[1]))
      else $error("software write changed a config word");
   // reads must answer exactly one cycle later once words are in
   chk_cpu_read: assert property (
      cpu_rd_i && core_ready_o |=> cpu_rvalid_o)
      else $error("software read not answered");
   // a command that arrives while words still load must be refused
   chk_early_refused: assert property (
      dbg_cmd_valid_i && !core_ready_o |=> dbg_error_o && !dbg_rvalid_o)
      else $error("debug command accepted before load");
endmodule

/* File: test/chw_dbg_host.sv */
`timescale 1ns/100ps
// ***********************************************************
// debug host model: issues background debug port commands
// ***********************************************************
module chw_dbg_host (
   output logic       dbg_cmd_valid_o,
   output logic [7:0] dbg_cmd_o
);
   // idle strobe low at time zero
   initial begin
      dbg_cmd_valid_o = 1'b0;
      dbg_cmd_o       = 8'h00;
   end

   // idle code line flips, so a stale code never looks fresh
   task automatic put(input logic valid, input logic [7:0] cmd);
      dbg_cmd_valid_o = valid;
      dbg_cmd_o       = valid ? cmd : ~dbg_cmd_o;
   endtask
endmodule

/* File: test/tb.sv */
`timescale 1ns/100ps
module tb;
   import chw_pkg::*;
   localparam logic [7:0] FAM = 8'h5a; // arbitrary value
   localparam logic [3:0] GEN = 4'h6;  // arbitrary value
   localparam logic [3:0] REV = 4'h4;  // arbitrary value
   localparam logic [4:0] FLS = 5'h0b;
   localparam logic [4:0] SRM = 5'h0d;
   localparam chw_word_t  CW  = {FAM, GEN, REV, 4'h8, 4'h0, 4'h2, 4'h9};
   localparam chw_word_t  MW  = {8'h10, FLS, 11'h010, SRM, 3'h0};
   logic       core_clk_i = 1'b0;
   logic       reset_n_i  = 1'b0;
   logic       cpu_rd_i   = 1'b0;
   logic       cpu_wr_i   = 1'b0;
   chw_idx_t   cpu_sel_i  = 1'b0;
   logic       dbg_cmd_valid_i, cpu_rvalid_o, write_refused_o;
   logic       dbg_rvalid_o, dbg_error_o, core_ready_o, rdy;
   logic [7:0] dbg_cmd_i;
   chw_word_t  cpu_rdata_o, dbg_rdata_o;
   logic [7:0] cmds [5] = '{8'h60, 8'h61, 8'h40, 8'h41, 8'h7f};
   logic [33:0] cpu_q[$], dbg_q[$], note, seen;
   int         n_fail = 0, checked = 0, wr_n = 0, i, seed;

   // free-running core clock, 4 ns period
   always #2 core_clk_i = ~core_clk_i;

   chw_dbg_host host (.dbg_cmd_valid_o(dbg_cmd_valid_i),
                      .dbg_cmd_o(dbg_cmd_i));
   chw_config_words #(.FAMILY_CODE(FAM), .GEN_CODE(GEN), .REV_CODE(REV),
      .MAC_PRESENT(1'b1), .FLASH_CODE(FLS), .SRAM_CODE(SRM)) dut (
      .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cpu_rd_i(cpu_rd_i),
      .cpu_sel_i(cpu_sel_i), .cpu_wr_i(cpu_wr_i),
      .cpu_rdata_o(cpu_rdata_o), .cpu_rvalid_o(cpu_rvalid_o),
      .write_refused_o(write_refused_o), .dbg_cmd_valid_i(dbg_cmd_valid_i),
      .dbg_cmd_i(dbg_cmd_i), .dbg_rdata_o(dbg_rdata_o),
      .dbg_rvalid_o(dbg_rvalid_o), .dbg_error_o(dbg_error_o),
      .core_ready_o(core_ready_o));

   task automatic cmp(string what, logic [33:0] exp, logic [33:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one cycle of stimulus; notes expected answers as it goes
   task automatic step(logic rd, logic sel, logic wr, logic dv,
                       logic [7:0] cmd);
      logic ok;
      @(posedge core_clk_i);
      #1;
      ok = rdy && (cmd == 8'h60 || cmd == 8'h61);
      cpu_rd_i  = rd;
      cpu_sel_i = sel;
      cpu_wr_i  = wr;
      host.put(dv, cmd);
      if (rd && rdy) cpu_q.push_back({1'b0, sel, sel ? MW : CW});
      if (wr) wr_n++;
      if (dv) dbg_q.push_back(ok ? {2'b01, cmd[0] ? MW : CW}
                                 : 34'h2_0000_0000);
   endtask

   // reset, then a debug load and a read while words still load
   task automatic do_reset();
      int n;
      reset_n_i = 1'b0;
      rdy       = 1'b0;
      repeat (20) @(posedge core_clk_i);
      #1;
      cmp("reset outputs", {29'h0, cpu_rvalid_o, write_refused_o,
          dbg_rvalid_o, dbg_error_o, core_ready_o}, 34'h0);
      reset_n_i = 1'b1;
      cpu_rd_i  = 1'b1;
      host.put(1'b1, 8'h60);
      dbg_q.push_back(34'h2_0000_0000);
      n = 0;
      while (core_ready_o !== 1'b1 && n < 20) begin
         @(posedge core_clk_i);
         #1;
         host.put(1'b0, 8'h00);
         cpu_rd_i = 1'b0;
         n++;
      end
      cmp("ready delay", 34'(n), 34'd3);
      rdy = 1'b1;
   endtask

   // monitor: oldest note against each answer that appears
   always @(negedge core_clk_i) begin
      if (cpu_rvalid_o !== 1'b0) begin
         note = cpu_q.size() > 0 ? cpu_q.pop_front() : 'x;
         seen = {2'b00, cpu_rdata_o};
         if (note[32]) begin
            cmp("mem word", note[31:0], seen[31:0]);
         end else begin
            cmp("core id", note[31:16], seen[31:16]);
            cmp("core engines", note[15:12], seen[15:12]);
            cmp("core levels", note[11:0], seen[11:0]);
         end
      end
      if ((dbg_rvalid_o | dbg_error_o) !== 1'b0) begin
         note = dbg_q.size() > 0 ? dbg_q.pop_front() : 'x;
         cmp("debug answer", note, {dbg_error_o, dbg_rvalid_o,
             dbg_rvalid_o ? dbg_rdata_o : 32'h0});
      end
      if (write_refused_o !== 1'b0) begin
         cmp("write refusal", 34'(wr_n > 0), 34'h1);
         wr_n--;
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // watchdog: whole run needs about 120 cycles
   initial begin
      #(4 * 3000);
      n_fail++;
      $display("mismatch watchdog expected finish seen timeout");
      print_verdict();
   end

   // test sequence: reset, directed, random, mid-run reset
   initial begin
      seed = $urandom(78);
      do_reset();
      $display("test reset_load done");
      for (i = 0; i < 5; i++) step(1'b1, i[0], 1'b1, 1'b1, cmds[i]);
      for (i = 0; i < 60; i++)
         step(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
              $urandom_range(1) ? cmds[$urandom_range(4)] : 8'($urandom));
      $display("test random_access done");
      repeat (3) step(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
      do_reset();
      for (i = 0; i < 4; i++) step(1'b1, ~i[0], 1'b0, 1'b1, cmds[i]);
      repeat (3) step(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
      $display("test second_reset done");
      cmp("pending notes", 34'(cpu_q.size() + dbg_q.size() + wr_n),
          34'h0);
      print_verdict();
   end
endmodule
